// File: design/port_a_io.sv
// Summary of operation
// - output pin follows latch when direction is 0
// - input level readable; analog selection blocks it
// - analog-default pins read digital 0 after reset
// - analog-capable pins come up in analog mode
// - bit six digital only in pin-free modes
// - bit six latch, direction, level read 0 otherwise
// - clock-out modes drive bit six at core/4
// - bit four feeds receive always, timer if input
// - bit seven unimplemented, reads 0, writes ignored
`timescale 1ns/10ps
`default_nettype none
module port_a_io (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [6:0] pin_in,
	output port_a_pkg::pad_drive_t pad_drive,
	output logic usb_xcvr_receive_in,
	output logic timer_zero_ext_clock_in,
	input wire logic [port_a_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [port_a_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import port_a_pkg::*;

	logic [6:0] sync1_r;
	logic [6:0] sync2_r;
	logic [6:0] latch_r;
	logic [6:0] dir_r;
	logic [6:0] analog_r;
	logic [2:0] osc_mode_r;
	logic [0:0] div_cnt_r;
	logic cycle_clk_r;
	pad_drive_t pad_drive_r;
	pad_drive_t pad_nxt;
	logic usb_rx_r;
	logic timer_clk_r;
	logic pin_free;
	logic clkout_mode;
	logic [6:0] level_view;
	logic [6:0] latch_view;
	logic [6:0] dir_view;
	logic awready_r;
	logic wready_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic arready_r;
	logic rvalid_r;
	logic [1:0] rresp_r;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic [1:0] rresp_nxt;
	logic aw_held_r;
	logic w_held_r;
	logic [ADDR_W-1:0] waddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic wr_fire;
	logic wr_mapped;

	// pins come from the board, so two flops before anything looks at them
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sync1_r <= 7'h00;
			sync2_r <= 7'h00;
		end else begin
			sync1_r <= pin_in;
			sync2_r <= sync1_r;
		end
	end

	// oscillator mode decides who owns bit six
	assign pin_free = (osc_mode_r == OSC_EXT_CLOCK_IO) || (osc_mode_r == OSC_EXT_PLL_PIN_FREE) ||
		(osc_mode_r == OSC_INT_PIN_FREE);
	assign clkout_mode = (osc_mode_r == OSC_EXT_CLOCK) || (osc_mode_r == OSC_EXT_PLL_CLOCKOUT) ||
		(osc_mode_r == OSC_INT_CLOCKOUT);

	// software views of the three port registers; bit seven never exists
	always_comb begin
		level_view = sync2_r & ~(analog_r & ANALOG_CAPABLE);
		latch_view = latch_r;
		dir_view = dir_r;
		if (!pin_free) begin
			level_view[CLK_PIN] = 1'b0;
			latch_view[CLK_PIN] = 1'b0;
			dir_view[CLK_PIN] = 1'b0;
		end
	end

	// divide-by-four cycle clock, free running so the pin never glitches on mode change
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			div_cnt_r <= 1'h0;
			cycle_clk_r <= 1'b0;
		end else begin
			div_cnt_r <= div_cnt_r + 1'h1;
			if (div_cnt_r == CYCLE_DIV_HALF) begin
				cycle_clk_r <= ~cycle_clk_r;
			end
		end
	end

	// pad drive: per-pin direction, bit six overridden by oscillator mode
	always_comb begin
		pad_nxt.out = latch_r;
		pad_nxt.oe = ~dir_r;
		if (clkout_mode) begin
			pad_nxt.out[CLK_PIN] = cycle_clk_r;
			pad_nxt.oe[CLK_PIN] = 1'b1;
		end else if (!pin_free) begin
			pad_nxt.out[CLK_PIN] = 1'b0;
			pad_nxt.oe[CLK_PIN] = 1'b0;
		end
	end

	// pad outputs registered; analog selection leaves the driver alone
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pad_drive_r <= '0;
		end else begin
			pad_drive_r <= pad_nxt;
		end
	end

	// bit four fans out to the transceiver input and the timer clock
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			usb_rx_r <= 1'b0;
			timer_clk_r <= 1'b0;
		end else begin
			usb_rx_r <= sync2_r[RX_PIN];
			timer_clk_r <= sync2_r[RX_PIN] & dir_r[RX_PIN];
		end
	end

	// write channel: address and data captured in either order
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			awready_r <= 1'b0;
			wready_r <= 1'b0;
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			waddr_r <= '0;
			wdata_r <= 32'h00000000;
			wstrb_r <= 4'h0;
		end else begin
			if (s_axi_awvalid && awready_r) begin
				aw_held_r <= 1'b1;
				waddr_r <= s_axi_awaddr;
				awready_r <= 1'b0;
			end else if (!aw_held_r && !bvalid_r) begin
				awready_r <= 1'b1;
			end
			if (s_axi_wvalid && wready_r) begin
				w_held_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
				wready_r <= 1'b0;
			end else if (!w_held_r && !bvalid_r) begin
				wready_r <= 1'b1;
			end
			if (wr_fire) begin
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
			end
		end
	end

	assign wr_fire = aw_held_r && w_held_r && !bvalid_r;
	assign wr_mapped = (waddr_r == OFS_PIN_LEVEL) || (waddr_r == OFS_LATCH) || (waddr_r == OFS_DIRECTION) ||
		(waddr_r == OFS_ANALOG_SEL) || (waddr_r == OFS_OSC_MODE);

	// write response, one per completed write
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_r <= 1'b1;
			bresp_r <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	// latch and direction; only byte lane 0 carries data, bit seven dropped
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			latch_r <= RST_LATCH;
			dir_r <= RST_DIRECTION;
		end else if (wr_fire && wstrb_r[0]) begin
			if ((waddr_r == OFS_PIN_LEVEL) || (waddr_r == OFS_LATCH)) begin
				latch_r <= wdata_r[6:0];
			end
			if (waddr_r == OFS_DIRECTION) begin
				dir_r <= wdata_r[6:0];
			end
		end
	end

	// analog selection and oscillator mode
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			analog_r <= RST_ANALOG_SEL;
			osc_mode_r <= RST_OSC_MODE;
		end else if (wr_fire && wstrb_r[0]) begin
			if (waddr_r == OFS_ANALOG_SEL) begin
				analog_r <= wdata_r[6:0] & ANALOG_CAPABLE;
			end
			if (waddr_r == OFS_OSC_MODE) begin
				osc_mode_r <= wdata_r[2:0];
			end
		end
	end

	// read mux; upper bits stay zero so bit seven reads 0
	always_comb begin
		rdata_nxt = 32'h00000000;
		rresp_nxt = RESP_OKAY;
		case (s_axi_araddr)
			OFS_PIN_LEVEL: rdata_nxt[6:0] = level_view;
			OFS_LATCH: rdata_nxt[6:0] = latch_view;
			OFS_DIRECTION: rdata_nxt[6:0] = dir_view;
			OFS_ANALOG_SEL: rdata_nxt[6:0] = analog_r;
			OFS_OSC_MODE: rdata_nxt[2:0] = osc_mode_r;
			default: rresp_nxt = RESP_SLVERR;
		endcase
	end

	// read channel: one read at a time, answer the cycle after address
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= RESP_OKAY;
		end else if (s_axi_arvalid && arready_r) begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b1;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
		end else if (rvalid_r) begin
			if (s_axi_rready) begin
				rvalid_r <= 1'b0;
			end
		end else begin
			arready_r <= 1'b1;
		end
	end

	assign pad_drive = pad_drive_r;
	assign usb_xcvr_receive_in = usb_rx_r;
	assign timer_zero_ext_clock_in = timer_clk_r;
	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

	// low pins drive the previous cycle's latch whenever direction was 0
	a_output_follows_latch: assert property (@(posedge core_clk) disable iff (rst)
		1'b1 |=> (pad_drive_r.oe[5:0] == ~$past(dir_r[5:0])) && (pad_drive_r.out[5:0] == $past(latch_r[5:0])))
		else $error("low pins do not follow latch and direction");

	// a level read returns the synchronised pin with analog pins masked
	a_level_read_value: assert property (@(posedge core_clk) disable iff (rst)
		(s_axi_arvalid && arready_r && (s_axi_araddr == OFS_PIN_LEVEL))
		|=> rvalid_r && (rdata_r[5:0] == $past(sync2_r[5:0] & ~(analog_r[5:0] & ANALOG_CAPABLE[5:0]))))
		else $error("pin level read mismatch");

	// a level read never returns a digital 1 on a pin held in analog mode
	a_analog_reads_zero: assert property (@(posedge core_clk) disable iff (rst)
		(s_axi_arvalid && arready_r && (s_axi_araddr == OFS_PIN_LEVEL))
		|=> ((rdata_r[6:0] & $past(analog_r)) == 7'h00))
		else $error("analog pin shows digital level");

	// just out of reset every capable pin is analog
	a_analog_por_default: assert property (@(posedge core_clk) disable iff (rst)
		$past(rst) |-> (analog_r == ANALOG_CAPABLE) && (level_view[5] == 1'b0))
		else $error("analog default missing after reset");

	// bit six digital level read gated by pin-free modes
	a_bit6_level_gated: assert property (@(posedge core_clk) disable iff (rst)
		!pin_free |-> (level_view[CLK_PIN] == 1'b0) && !(pad_drive_r.oe[CLK_PIN] && !$past(clkout_mode)
		&& $past(!pin_free)))
		else $error("bit six live outside pin-free mode");

	// bit six latch and direction read zero when the pin is taken
	a_bit6_regs_gated: assert property (@(posedge core_clk) disable iff (rst)
		(s_axi_arvalid && arready_r && !pin_free && ((s_axi_araddr == OFS_LATCH) || (s_axi_araddr == OFS_DIRECTION)))
		|=> (rdata_r[CLK_PIN] == 1'b0))
		else $error("bit six register visible");

	// clock-out modes: pad enabled and toggling with period four
	a_clock_out_drive: assert property (@(posedge core_clk) disable iff (rst)
		(clkout_mode && $past(clkout_mode, 1) && $past(clkout_mode, 2) && $past(clkout_mode, 3))
		|-> pad_drive_r.oe[CLK_PIN] && (pad_drive_r.out[CLK_PIN] != $past(pad_drive_r.out[CLK_PIN], 2)))
		else $error("cycle clock not driven at core/4");

	// bit four fan-out to receive and timer inputs
	a_bit4_fanout: assert property (@(posedge core_clk) disable iff (rst)
		1'b1 |=> (usb_rx_r == $past(sync2_r[RX_PIN])) && (timer_clk_r == ($past(sync2_r[RX_PIN]) && $past(dir_r[RX_PIN]))))
		else $error("bit four fan-out wrong");

	// nothing above bit six ever reads back
	a_upper_bits_zero: assert property (@(posedge core_clk) disable iff (rst)
		rvalid_r |-> (rdata_r[31:7] == 25'h0000000))
		else $error("unimplemented bits read nonzero");

	// a level-address write lands in the latch
	a_level_write_latch: assert property (@(posedge core_clk) disable iff (rst)
		(wr_fire && wstrb_r[0] && (waddr_r == OFS_PIN_LEVEL)) |=> (latch_r == $past(wdata_r[6:0])))
		else $error("pin level write did not update latch");

	// a level read outside the pin-free modes never shows bit six
	a_bit6_read_zero: assert property (@(posedge core_clk) disable iff (rst)
		(s_axi_arvalid && arready_r && !pin_free && (s_axi_araddr == OFS_PIN_LEVEL))
		|=> (rdata_r[CLK_PIN] == 1'b0))
		else $error("bit six level visible outside pin-free mode");

	// in a pin-free mode bit six behaves as an ordinary port pin
	a_bit6_free_drive: assert property (@(posedge core_clk) disable iff (rst)
		pin_free |=> (pad_drive_r.oe[CLK_PIN] == ~$past(dir_r[CLK_PIN]))
		&& (pad_drive_r.out[CLK_PIN] == $past(latch_r[CLK_PIN])))
		else $error("bit six does not follow latch in pin-free mode");

endmodule // port_a_io
`default_nettype wire

// File: design/port_a_pkg.sv
`default_nettype none
package port_a_pkg;

	// port geometry
	localparam int PIN_COUNT = 7;
	localparam int CLK_PIN = 6;
	localparam int RX_PIN = 4;
	localparam int ADDR_W = 8;

	// register byte offsets
	localparam logic [7:0] OFS_PIN_LEVEL = 8'h00;
	localparam logic [7:0] OFS_LATCH = 8'h04;
	localparam logic [7:0] OFS_DIRECTION = 8'h08;
	localparam logic [7:0] OFS_ANALOG_SEL = 8'h0C;
	localparam logic [7:0] OFS_OSC_MODE = 8'h10;

	// oscillator mode codes held in the mode register
	localparam logic [2:0] OSC_CRYSTAL = 3'h0;
	localparam logic [2:0] OSC_EXT_CLOCK = 3'h1;
	localparam logic [2:0] OSC_EXT_CLOCK_IO = 3'h2;
	localparam logic [2:0] OSC_EXT_PLL_CLOCKOUT = 3'h3;
	localparam logic [2:0] OSC_EXT_PLL_PIN_FREE = 3'h4;
	localparam logic [2:0] OSC_INT_PIN_FREE = 3'h5;
	localparam logic [2:0] OSC_INT_CLOCKOUT = 3'h6;

	// pins that can be taken over by an analog converter channel
	localparam logic [6:0] ANALOG_CAPABLE = 7'h2F;

	// values after reset
	localparam logic [6:0] RST_LATCH = 7'h00;
	localparam logic [6:0] RST_DIRECTION = 7'h7F;
	localparam logic [6:0] RST_ANALOG_SEL = 7'h2F;
	localparam logic [2:0] RST_OSC_MODE = 3'h5;

	// cycle clock is the core clock divided by four: toggle every two cycles
	localparam logic [0:0] CYCLE_DIV_HALF = 1'h1;

	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// pad drive carried as one bundle
	typedef struct packed {
		logic [6:0] out;
		logic [6:0] oe;
	} pad_drive_t;

endpackage
`default_nettype wire

// File: verification/board_pins.sv
`timescale 1ns/10ps
`default_nettype none
module board_pins
	import port_a_pkg::*;
(
	input wire port_a_pkg::pad_drive_t pad_drive,
	input wire logic [6:0] board_level,
	output logic [6:0] pin_in
);
	// a driven pad wins; a released pad shows the board's own level, never the stale pad value
	always_comb begin
		for (int i = 0; i < PIN_COUNT; i++) begin
			pin_in[i] = pad_drive.oe[i] ? pad_drive.out[i] : board_level[i];
		end
	end
endmodule // board_pins
`default_nettype wire

// File: verification/seven_bit_port_a_io_test.sv
`timescale 1ns/10ps
`default_nettype none
module seven_bit_port_a_io_test;
	import port_a_pkg::*;
	logic core_clk, rst, usb_rx, tmr_clk, fr, ck, b;
	logic [6:0] board_level, pin_in;
	pad_drive_t pad_drive;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb, m;
	logic [1:0] bresp, rresp;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	int fail_count, total_checks;

	port_a_io port_a_io_inst (.core_clk(core_clk), .rst(rst), .pin_in(pin_in), .pad_drive(pad_drive),
		.usb_xcvr_receive_in(usb_rx), .timer_zero_ext_clock_in(tmr_clk),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready));
	board_pins board_pins_inst (.pad_drive(pad_drive), .board_level(board_level), .pin_in(pin_in));

	// free running core clock, 4 ns period
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_pin(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask

	task automatic close_out;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// handshakes are judged on negedge samples, which equal what the next rising edge sees
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ah, wh, bh;
		logic [1:0] r;
		int n;
		@(posedge core_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(negedge core_clk);
			ah = awvalid && awready;
			wh = wvalid && wready;
			bh = bvalid;
			r = bresp;
			@(posedge core_clk);
			if (ah) awvalid <= 1'b0;
			if (wh) wvalid <= 1'b0;
			if (bh) break;
		end
		bready <= 1'b0;
		if (n == 50) begin
			fail_count++;
			close_out;
		end else begin
			chk({30'h0, r}, {30'h0, er});
		end
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic ah, rh;
		logic [31:0] d;
		logic [1:0] r;
		int n;
		@(posedge core_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(negedge core_clk);
			ah = arvalid && arready;
			rh = rvalid;
			d = rdata;
			r = rresp;
			@(posedge core_clk);
			if (ah) arvalid <= 1'b0;
			if (rh) break;
		end
		rready <= 1'b0;
		if (n == 50) begin
			fail_count++;
			close_out;
		end else begin
			chk(d, ed);
			chk({30'h0, r}, {30'h0, er});
		end
	endtask

	// set the board level, then give sync flops and pad registers time to settle
	task automatic settle(input logic [6:0] v);
		@(posedge core_clk);
		board_level <= v;
		repeat (6) @(posedge core_clk);
		@(negedge core_clk);
	endtask

	// main sequence
	initial begin
		rst = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		{awaddr, araddr, wdata} = 48'h0;
		wstrb = 4'hF;
		board_level = 7'h7F;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		rd_chk(OFS_DIRECTION, 32'h7F, RESP_OKAY);
		rd_chk(OFS_LATCH, 32'h00, RESP_OKAY);
		rd_chk(OFS_ANALOG_SEL, 32'h2F, RESP_OKAY);
		rd_chk(OFS_PIN_LEVEL, 32'h50, RESP_OKAY);
		wr(8'h14, 32'h1, RESP_SLVERR);
		rd_chk(8'h14, 32'h0, RESP_SLVERR);
		wr(OFS_PIN_LEVEL, 32'hFFFFFFFF, RESP_OKAY);
		rd_chk(OFS_LATCH, 32'h7F, RESP_OKAY);
		wr(OFS_DIRECTION, 32'h0, RESP_OKAY);
		settle(7'h00);
		chk({25'h0, pad_drive.oe}, 32'h7F);
		chk({25'h0, pad_drive.out}, 32'h7F);
		rd_chk(OFS_PIN_LEVEL, 32'h50, RESP_OKAY);
		wr(OFS_ANALOG_SEL, 32'h0, RESP_OKAY);
		rd_chk(OFS_PIN_LEVEL, 32'h7F, RESP_OKAY);
		wr(OFS_LATCH, 32'h2A, RESP_OKAY);
		rd_chk(OFS_LATCH, 32'h2A, RESP_OKAY);
		// a write with byte lane 0 switched off must leave the latch alone
		wstrb <= 4'hE;
		wr(OFS_LATCH, 32'h55, RESP_OKAY);
		wstrb <= 4'hF;
		rd_chk(OFS_LATCH, 32'h2A, RESP_OKAY);
		settle(7'h00);
		chk({25'h0, pad_drive.out}, 32'h2A);
		wr(OFS_LATCH, 32'h7F, RESP_OKAY);
		wr(OFS_DIRECTION, 32'h10, RESP_OKAY);
		settle(7'h10);
		chk_pin(usb_rx, 1'b1);
		chk_pin(tmr_clk, 1'b1);
		settle(7'h00);
		chk_pin(usb_rx, 1'b0);
		chk_pin(tmr_clk, 1'b0);
		// all pins inputs: a level read returns the board's own pattern
		wr(OFS_DIRECTION, 32'h7F, RESP_OKAY);
		settle(7'h55);
		rd_chk(OFS_PIN_LEVEL, 32'h55, RESP_OKAY);
		wr(OFS_DIRECTION, 32'h0, RESP_OKAY);
		settle(7'h00);
		chk_pin(usb_rx, 1'b1);
		chk_pin(tmr_clk, 1'b0);
		// every oscillator mode: pin-free modes keep bit six, clock-out modes toggle it at core/4
		for (m = 4'h0; m < 4'h8; m++) begin
			wr(OFS_OSC_MODE, {28'h0, m}, RESP_OKAY);
			fr = (m == 4'h2) || (m == 4'h4) || (m == 4'h5);
			ck = (m == 4'h1) || (m == 4'h3) || (m == 4'h6);
			rd_chk(OFS_LATCH, {25'h0, fr, 6'h3F}, RESP_OKAY);
			rd_chk(OFS_PIN_LEVEL, {25'h0, fr, 6'h3F}, RESP_OKAY);
			settle(7'h00);
			chk_pin(pad_drive.oe[6], fr || ck);
			if (ck) begin
				b = pad_drive.out[6];
				repeat (2) @(negedge core_clk);
				chk_pin(pad_drive.out[6], ~b);
				repeat (2) @(negedge core_clk);
				chk_pin(pad_drive.out[6], b);
			end
		end
		wr(OFS_DIRECTION, 32'hFF, RESP_OKAY);
		rd_chk(OFS_DIRECTION, 32'h3F, RESP_OKAY);
		// clock-out mode drives bit six even with its direction bit set
		wr(OFS_OSC_MODE, 32'h6, RESP_OKAY);
		settle(7'h00);
		chk({25'h0, pad_drive.oe}, 32'h40);
		wr(OFS_OSC_MODE, 32'h5, RESP_OKAY);
		rd_chk(OFS_DIRECTION, 32'h7F, RESP_OKAY);
		// reset again mid-run: registers and pads must return to their power-on state
		rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		rd_chk(OFS_ANALOG_SEL, 32'h2F, RESP_OKAY);
		rd_chk(OFS_LATCH, 32'h00, RESP_OKAY);
		rd_chk(OFS_OSC_MODE, 32'h5, RESP_OKAY);
		settle(7'h7F);
		chk({25'h0, pad_drive.oe}, 32'h00);
		rd_chk(OFS_PIN_LEVEL, 32'h50, RESP_OKAY);
		close_out;
	end
endmodule // seven_bit_port_a_io_test
`default_nettype wire
